// ### vlta_pkg.sv
// vlta_pkg: shared constants and carriers for the indirect table access
// block (vlan set table and learned address table read-out).
// assumes a single system clock; imported by every design file.
package vlta_pkg;

  // ----------------------------------------------------------------------
  // register offsets on the management port
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h6e;       // indirect_table_control
  localparam logic [7:0] ADDR_ALO = 8'h6f;        // address low + trigger
  localparam logic [7:0] ADDR_DATA_FIRST = 8'h70; // data bits 71:64
  localparam logic [7:0] ADDR_DATA_LAST = 8'h78;  // data bits 7:0
  localparam logic [7:0] ADDR_DATA116 = 8'h74;    // indirect_data_byte_116
  localparam logic [7:0] ADDR_DATA117 = 8'h75;    // indirect_data_byte_117

  // ----------------------------------------------------------------------
  // control register fields (0x14 vlan read, 0x04 vlan write,
  // 0x18 learned table read)
  // ----------------------------------------------------------------------
  localparam int CTRL_RD_BIT = 4;
  localparam int CTRL_SEL_HI = 3;
  localparam int CTRL_SEL_LO = 2;
  localparam logic [1:0] SEL_VLAN = 2'h1;
  localparam logic [1:0] SEL_DYN = 2'h2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ALO_RST = 8'h00;

  // ----------------------------------------------------------------------
  // data word layout
  // ----------------------------------------------------------------------
  localparam int DATA_W = 72;
  localparam int DATA_BYTES = 9;
  localparam int SET_W = 52;
  localparam int ENTRY_W = 13;
  localparam int SET_ADDR_W = 10;
  localparam int VLAN_SETS = 1024;
  localparam int DYN_EMPTY_BIT = 71;
  localparam int DYN_CNT_HI = 70;
  localparam int DYN_CNT_LO = 61;
  localparam int DYN_READY_BIT = 55;
  localparam logic [71:0] DATA_RST = 72'h80_0000_0000_0000_0000;
  localparam logic [12:0] ENTRY_RST = 13'h0f80; // membership all ones
  localparam logic [51:0] SET_RST = {4{ENTRY_RST}};

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vlta_reg_req_t;

  typedef struct packed {
    logic valid;             // bit 12
    logic [4:0] member;      // bits 11:7
    logic [6:0] filter_group_id; // bits 6:0
  } vlta_vlan_entry_t;

  typedef struct packed {
    logic [1:0] age;         // aging counter
    logic [2:0] port;        // 0 = port 1 .. 4 = port 5
    logic [6:0] filter_group_id;
    logic [47:0] mac;
  } vlta_dyn_entry_t;

endpackage

// ### vlta_vlan_mem.sv
// vlta_vlan_mem: vlan set storage, one write port, two read ports.
// assumes writes come only from the indirect access logic.
`timescale 1ns/10ps
module vlta_vlan_mem #(
  parameter int SETS = 1024,
  parameter int W = 52,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [vlta_pkg::SET_ADDR_W-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [vlta_pkg::SET_ADDR_W-1:0] i_raddr_a,
  output logic [W-1:0] o_rdata_a,
  input wire logic [vlta_pkg::SET_ADDR_W-1:0] i_raddr_b,
  output logic [W-1:0] o_rdata_b
);
  import vlta_pkg::*;

  localparam int AW = $clog2(SETS);

  logic [W-1:0] mem_q [SETS];

  // flip-flop array; reset loads the suggested initial entries
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < SETS; i++) begin
        mem_q[i] <= RST_VAL;
      end
    end else if (i_we) begin
      mem_q[i_waddr[AW-1:0]] <= i_wdata;
    end
  end

  // read ports are plain muxes over the array
  assign o_rdata_a = mem_q[i_raddr_a[AW-1:0]];
  assign o_rdata_b = mem_q[i_raddr_b[AW-1:0]];

endmodule

// ### vlta_table_access.sv
// vlta_table_access: indirect control/address/data registers for the
// vlan set table and the learned address table.
// assumes the management transport delivers one-cycle register strobes
// and the learning logic answers table reads on the same clock.
//
// Summary of operation
// - control value 0x14 selects a vlan table read.
// - write to address low register sets low set address and triggers.
// - control value 0x04 selects a vlan write of the 52-bit data word.
// - vlan set read result appears in data registers 114 to 120.
// - entry two maps to reg 116 bits 6:0 and reg 117 bits 7:2.
// - set address is vid/4; vid mod 4 picks the 13-bit slice.
// - learned table is read-only; only learning logic changes it.
// - learned entry: filter group id 54:48, station address 47:0.
// - bit 71 set when table empty, cleared otherwise; resets to 1.
// - bits 70:61 give valid count minus one, zero when empty.
// - bits 60:59 carry the two-bit aging counter.
// - bits 58:56 carry learned port, 000 port 1 up to 100 port 5.
// - bit 55 stays 1 until entry valid; host re-reads until 0.
// - set address bits 9:8 come from control bits 1:0, 7:0 from low.
// - entry: valid bit 12, membership 11:7, filter group id 6:0.
// - control value 0x18 selects a learned read into regs 112-120.
`timescale 1ns/10ps
module vlta_table_access #(
  parameter int SETS = vlta_pkg::VLAN_SETS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire vlta_pkg::vlta_reg_req_t i_reg,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_dyn_req,
  output logic [vlta_pkg::SET_ADDR_W-1:0] o_dyn_addr,
  input wire logic i_dyn_ack,
  input wire vlta_pkg::vlta_dyn_entry_t i_dyn_entry,
  input wire logic [10:0] i_dyn_count,
  input wire logic [11:0] i_lookup_vid,
  output vlta_pkg::vlta_vlan_entry_t o_lookup_entry
);
  import vlta_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } vlta_state_t;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  vlta_state_t state_q, state_d;
  logic [7:0] ctrl_q;
  logic [7:0] alo_q;
  logic [DATA_W-1:0] data_q, data_d;
  logic [SET_ADDR_W-1:0] dyn_addr_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  vlta_vlan_entry_t lookup_q;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire wr_ctrl = i_reg.wr && (i_reg.addr == ADDR_CTRL);
  wire wr_trig = i_reg.wr && (i_reg.addr == ADDR_ALO);
  wire is_read = ctrl_q[CTRL_RD_BIT];
  wire [1:0] sel = ctrl_q[CTRL_SEL_HI:CTRL_SEL_LO];
  // 0x14 reads, 0x04 writes the vlan table; 0x18 reads learned table
  wire vlan_rd_go = wr_trig && (sel == SEL_VLAN) && is_read;
  wire vlan_wr_go = wr_trig && (sel == SEL_VLAN) && !is_read;
  wire dyn_go = wr_trig && (sel == SEL_DYN) && is_read;
  // the trigger byte is the new low address, used in the same cycle
  wire [SET_ADDR_W-1:0] trig_addr = {ctrl_q[1:0], i_reg.wdata};
  wire [SET_ADDR_W-1:0] set_addr = {ctrl_q[1:0], alo_q};
  wire [SET_ADDR_W-1:0] port_a_addr = wr_trig ? trig_addr : set_addr;
  // a fresh trigger drops a late answer for the previous address
  wire dyn_done = (state_q == ST_WAIT) && i_dyn_ack && !wr_trig;

  // ----------------------------------------------------------------------
  // vlan set storage
  // ----------------------------------------------------------------------
  logic [SET_W-1:0] vset_a;
  logic [SET_W-1:0] vset_b;

  vlta_vlan_mem #(
    .SETS(SETS),
    .W(SET_W),
    .RST_VAL(SET_RST)
  ) u_mem (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_we(vlan_wr_go),
    .i_waddr(trig_addr),
    .i_wdata(data_q[SET_W-1:0]), // whole set written back
    .i_raddr_a(port_a_addr),
    .o_rdata_a(vset_a),
    .i_raddr_b(i_lookup_vid[11:2]),
    .o_rdata_b(vset_b)
  );

  // vid / 4 picks the set, vid mod 4 the slice
  wire [ENTRY_W-1:0] lk_slice =
    vset_b[ENTRY_W*i_lookup_vid[1:0] +: ENTRY_W];

  // ----------------------------------------------------------------------
  // learned entry assembly
  // ----------------------------------------------------------------------
  wire dyn_empty = (i_dyn_count == 11'h000);
  wire [9:0] cnt_m1 = 10'(i_dyn_count - 11'h001);
  wire [9:0] cnt_field = dyn_empty ? 10'h000 : cnt_m1;
  // bit 55 cleared: the entry is ready when it lands
  wire [DATA_W-1:0] dyn_word = {dyn_empty, cnt_field,
    i_dyn_entry.age, i_dyn_entry.port, 1'b0,
    i_dyn_entry.filter_group_id, i_dyn_entry.mac};

  // ----------------------------------------------------------------------
  // read-back byte lanes, register 112 first
  // ----------------------------------------------------------------------
  logic [7:0] data_byte [DATA_BYTES];
  genvar g;
  generate
    for (g = 0; g < DATA_BYTES; g++) begin : g_lane
      assign data_byte[g] = data_q[DATA_W-1-8*g -: 8];
    end
  endgenerate

  wire [7:0] rd_idx = i_reg.addr - ADDR_DATA_FIRST;
  wire rd_data_hit = (i_reg.addr >= ADDR_DATA_FIRST) &&
    (i_reg.addr <= ADDR_DATA_LAST);
  // unmapped offsets read as zero
  wire [7:0] rd_mux = (i_reg.addr == ADDR_CTRL) ? ctrl_q :
    (i_reg.addr == ADDR_ALO) ? alo_q :
    rd_data_hit ? data_byte[rd_idx[3:0]] : 8'h00;

  // ----------------------------------------------------------------------
  // data register next value
  // ----------------------------------------------------------------------
  // a direct byte write is applied last so host edits always stick
  always_comb begin
    data_d = data_q;
    if (vlan_rd_go) begin
      data_d[SET_W-1:0] = vset_a;
    end
    if (dyn_go) begin
      data_d[DYN_READY_BIT] = 1'b1;
    end
    if (dyn_done) begin
      data_d = dyn_word;
    end
    for (int k = 0; k < DATA_BYTES; k++) begin
      if (i_reg.wr && (i_reg.addr == ADDR_DATA_FIRST + 8'(k))) begin
        data_d[DATA_W-1-8*k -: 8] = i_reg.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // learned read sequencer
  // ----------------------------------------------------------------------
  // the learned table has no write path here at all
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (dyn_go) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wr_trig && !dyn_go) begin
          state_d = ST_IDLE;
        end else if (dyn_done) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      ctrl_q <= CTRL_RST;
      alo_q <= ALO_RST;
      data_q <= DATA_RST; // empty flag starts set
      dyn_addr_q <= '0;
    end else begin
      state_q <= state_d;
      ctrl_q <= wr_ctrl ? i_reg.wdata : ctrl_q;
      alo_q <= wr_trig ? i_reg.wdata : alo_q;
      data_q <= data_d;
      dyn_addr_q <= dyn_go ? trig_addr : dyn_addr_q;
    end
  end

  // read data and vlan lookup answer, one cycle after the request
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      lookup_q <= vlta_vlan_entry_t'(ENTRY_RST);
    end else begin
      rdata_q <= i_reg.rd ? rd_mux : rdata_q;
      rvalid_q <= i_reg.rd;
      lookup_q <= vlta_vlan_entry_t'(lk_slice);
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_dyn_req = (state_q == ST_WAIT);
  assign o_dyn_addr = dyn_addr_q;
  assign o_lookup_entry = lookup_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  wire host_data_wr = i_reg.wr && rd_data_hit;

  property p_vlan_rd;
    vlan_rd_go |=> (data_q[SET_W-1:0] == $past(vset_a));
  endproperty
  a_vlan_rd: assert property (p_vlan_rd)
    else $error("vlan set read not loaded");

  property p_vlan_wr;
    vlan_wr_go ##1 !wr_trig |-> (vset_a == $past(data_q[SET_W-1:0]));
  endproperty
  a_vlan_wr: assert property (p_vlan_wr)
    else $error("vlan set write not stored");

  property p_trig_addr;
    wr_trig |=> (set_addr == {$past(ctrl_q[1:0]), $past(i_reg.wdata)});
  endproperty
  a_trig_addr: assert property (p_trig_addr)
    else $error("set address not formed from trigger");

  property p_ready_hold;
    dyn_go ##1 (!i_dyn_ack && !host_data_wr && !wr_trig)
      |=> data_q[DYN_READY_BIT] && o_dyn_req;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready bit dropped before answer");

  property p_dyn_empty;
    dyn_done && !host_data_wr
      |=> data_q[DYN_EMPTY_BIT] == ($past(i_dyn_count) == 11'h000);
  endproperty
  a_dyn_empty: assert property (p_dyn_empty)
    else $error("empty flag wrong");

  property p_dyn_count;
    dyn_done && !host_data_wr && (i_dyn_count != 11'h000)
      |=> data_q[DYN_CNT_HI:DYN_CNT_LO] ==
        10'($past(i_dyn_count) - 11'h001);
  endproperty
  a_dyn_count: assert property (p_dyn_count)
    else $error("valid count field wrong");

  property p_dyn_fields;
    dyn_done && !host_data_wr |=> !data_q[DYN_READY_BIT] &&
      (data_q[60:0] == {$past(i_dyn_entry[59:55]), 1'b0,
        $past(i_dyn_entry[54:0])});
  endproperty
  a_dyn_fields: assert property (p_dyn_fields)
    else $error("learned entry fields wrong");

  property p_lookup;
    1'b1 |=> o_lookup_entry ==
      $past(vset_b[ENTRY_W*i_lookup_vid[1:0] +: ENTRY_W]);
  endproperty
  a_lookup: assert property (p_lookup)
    else $error("lookup slice wrong");

  property p_reg116;
    i_reg.rd && (i_reg.addr == ADDR_DATA116)
      |=> o_reg_rdata[6:0] == $past(data_q[38:32]) && o_reg_rvalid;
  endproperty
  a_reg116: assert property (p_reg116)
    else $error("data byte at 0x74 lane wrong");

  property p_reg117;
    i_reg.rd && (i_reg.addr == ADDR_DATA117)
      |=> o_reg_rdata[7:2] == $past(data_q[31:26]);
  endproperty
  a_reg117: assert property (p_reg117)
    else $error("data byte at 0x75 lane wrong");

  property p_hold;
    !wr_trig && !host_data_wr && !dyn_done |=> $stable(data_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("data changed without cause");

  property p_no_dyn_write;
    wr_trig && (sel == SEL_DYN) && !is_read |=> state_q == ST_IDLE;
  endproperty
  a_no_dyn_write: assert property (p_no_dyn_write)
    else $error("learned table write accepted");

endmodule

// ### test_vlta_table_access.sv
// test_vlta_table_access: self-checking bench for the indirect table access
// block, driving the management strobes and the learning-logic handshake.
// assumes vlta_pkg is compiled first; single 100 MHz clock, async reset.
`timescale 1ns/10ps
module test_vlta_table_access;
  import vlta_pkg::*;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam int LIMIT = 5000; // whole run needs well under 2000 cycles
  logic i_clk;
  logic i_rst;
  vlta_reg_req_t i_reg;
  logic [7:0] o_reg_rdata;
  logic o_reg_rvalid;
  logic o_dyn_req;
  logic [SET_ADDR_W-1:0] o_dyn_addr;
  logic i_dyn_ack;
  vlta_dyn_entry_t i_dyn_entry;
  logic [10:0] i_dyn_count;
  logic [11:0] i_lookup_vid;
  vlta_vlan_entry_t o_lookup_entry;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [71:0] w; // expected data word, kept in step with every access
  logic [51:0] sets [VLAN_SETS];
  int counts [5] = '{1, 2, 1024, 517, 3};

  vlta_table_access #(.SETS(VLAN_SETS)) i_vlta_table_access (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_reg(i_reg),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .o_dyn_req(o_dyn_req),
    .o_dyn_addr(o_dyn_addr),
    .i_dyn_ack(i_dyn_ack),
    .i_dyn_entry(i_dyn_entry),
    .i_dyn_count(i_dyn_count),
    .i_lookup_vid(i_lookup_vid),
    .o_lookup_entry(o_lookup_entry)
  );

  // ------------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      test_done();
    end
  end

  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one strobe, then an idle edge so the next call never re-drives
  // the strobe in the time step where it was lowered
  task automatic reg_op(input logic wr, input logic [7:0] a, d);
    @(posedge i_clk);
    i_reg <= '{wr: wr, rd: ~wr, addr: a, wdata: d};
    @(posedge i_clk);
    i_reg <= '0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, d);
    reg_op(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, exp);
    reg_op(1'b0, a, 8'h00);
    chk(72'(o_reg_rvalid), 72'h1);
    chk(72'(o_reg_rdata), 72'(exp));
  endtask

  // direct data byte write, mirrored into the expected word
  task automatic wd(input logic [7:0] a, d);
    wr(a, d);
    w[8 * (8 - int'(a - ADDR_DATA_FIRST)) +: 8] = d;
  endtask

  task automatic rd_all();
    for (int i = 0; i < DATA_BYTES; i++) begin
      rd(ADDR_DATA_FIRST + 8'(i), w[8 * (8 - i) +: 8]);
    end
  endtask

  task automatic vlan_rd(input logic [9:0] s);
    wr(ADDR_CTRL, {6'h05, s[9:8]});
    wr(ADDR_ALO, s[7:0]);
    w[51:0] = sets[s];
  endtask

  task automatic vlan_wr(input logic [9:0] s);
    wr(ADDR_CTRL, {6'h01, s[9:8]});
    wr(ADDR_ALO, s[7:0]);
    sets[s] = w[51:0];
  endtask

  task automatic lk(input logic [11:0] vid);
    logic [51:0] s;
    s = sets[vid[11:2]];
    @(posedge i_clk);
    i_lookup_vid <= vid;
    @(posedge i_clk);
    #1;
    chk(72'(o_lookup_entry), 72'(s[13 * vid[1:0] +: 13]));
  endtask

  // learned read: wait state shows not-ready, then the ack loads the word
  task automatic dyn(input logic [1:0] hi, input logic [7:0] lo,
                     input logic [10:0] cnt, input logic [2:0] port);
    vlta_dyn_entry_t e;
    e = '{age: 2'h2, port: port, filter_group_id: {4'h5, port},
          mac: {40'h0a1b2c3d4e, lo}};
    wr(ADDR_CTRL, {6'h06, hi});
    wr(ADDR_ALO, lo);
    chk(72'({o_dyn_req, o_dyn_addr}), 72'({1'b1, hi, lo}));
    reg_op(1'b0, 8'h72, 8'h00);
    chk(72'(o_reg_rdata[7]), 72'h1);
    @(posedge i_clk);
    i_dyn_ack <= 1'b1;
    i_dyn_entry <= e;
    i_dyn_count <= cnt;
    @(posedge i_clk);
    i_dyn_ack <= 1'b0;
    #1;
    chk(72'(o_dyn_req), 72'h0);
    w = {cnt == 11'd0, (cnt == 11'd0) ? 10'h0 : 10'(cnt - 11'd1), e.age,
         e.port, 1'b0, e.filter_group_id, e.mac};
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    i_reg = '0;
    i_dyn_ack = 1'b0;
    i_dyn_entry = '0;
    i_dyn_count = '0;
    i_lookup_vid = '0;
    w = DATA_RST;
    for (int i = 0; i < VLAN_SETS; i++) begin
      sets[i] = SET_RST;
    end
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_all();
    rd(8'h6a, 8'h00);
    lk(12'd10);
    // edit only the vid 10 entry of set 2, keeping neighbour bits
    vlan_rd(10'd2);
    rd_all();
    wd(ADDR_DATA116, {w[39], 7'h6b});
    wd(ADDR_DATA117, {6'h2d, w[25:24]});
    vlan_wr(10'd2);
    // the edited entry must come back from the stored set itself
    @(posedge i_clk);
    i_lookup_vid <= 12'd10;
    @(posedge i_clk);
    #1;
    chk(72'(o_lookup_entry), 72'h1aed);
    for (int v = 8; v < 12; v++) begin
      lk(12'(v));
    end
    // direct byte write stays until the next vlan read
    wd(ADDR_DATA_LAST, 8'hc3);
    rd_all();
    vlan_rd(10'd5);
    rd_all();
    vlan_rd(10'd2);
    rd_all();
    // high set address bits come from the control register
    wd(8'h72, 8'h0e);
    wd(8'h76, 8'h81);
    vlan_wr(10'h3ff);
    wd(8'h77, 8'h5c);
    vlan_wr(10'h100);
    lk(12'hfff);
    lk(12'hffc);
    lk(12'h400);
    lk(12'h403);
    vlan_rd(10'h3ff);
    rd_all();
    // learned reads: empty table, then each port and several counts
    dyn(2'b00, 8'h00, 11'd0, 3'd0);
    rd_all();
    for (int p = 0; p < 5; p++) begin
      dyn(2'b01, 8'h01, 11'(counts[p]), 3'(p));
      rd_all();
    end
    // a learned write select is not honoured: table stays read-only
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_ALO, 8'h05);
    chk(72'(o_dyn_req), 72'h0);
    rd_all();
    rd(ADDR_CTRL, 8'h08);
    rd(ADDR_ALO, 8'h05);
    test_done();
  end
endmodule
